// [alm_pkg.sv]
// constants for the access control entry port, flag and ethertype matcher
package alm_pkg;
   // criterion mode encodings for ports and ethertype
   localparam logic [1:0] MODE_ANY = 2'h0;
   localparam logic [1:0] MODE_EXACT = 2'h1;
   localparam logic [1:0] MODE_RANGE = 2'h2;
   // tcp flag criterion encodings
   localparam logic [1:0] FLAG_ZERO = 2'h0;
   localparam logic [1:0] FLAG_ONE = 2'h1;
   localparam logic [1:0] FLAG_ANY = 2'h2;
   localparam int NUM_FLAGS = 6;
   // flag bit positions in flag vectors
   localparam int FLAG_FIN = 0;
   localparam int FLAG_SYN = 1;
   localparam int FLAG_RST = 2;
   localparam int FLAG_PSH = 3;
   localparam int FLAG_ACK = 4;
   localparam int FLAG_URG = 5;
   // frame classes
   localparam logic [1:0] CLASS_ETYPE = 2'h1;
   // ethertype limits
   localparam logic [15:0] ETYPE_MIN = 16'h0600;
   localparam logic [15:0] ETYPE_IPV4 = 16'h0800;
   localparam logic [15:0] ETYPE_ARP = 16'h0806;
   localparam logic [15:0] ETYPE_IPV6 = 16'h86dd;
   // register map
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_SPORT = 8'h04;
   localparam logic [7:0] OFF_DPORT = 8'h08;
   localparam logic [7:0] OFF_ETYPE = 8'h0c;
   localparam logic [7:0] OFF_STAT = 8'h10;
   // control field positions and port upper bound position
   localparam int CTL_SMODE = 0;
   localparam int CTL_DMODE = 2;
   localparam int CTL_EMODE = 4;
   localparam int CTL_CLASS = 6;
   localparam int CTL_FLAGS = 8;
   localparam int CTL_EN = 20;
   localparam int HI_POS = 16;
   // axi responses and control register reset value
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0aaa;
endpackage

// [alm_matcher.sv]
// access control entry matcher with its axi4-lite register slave
// How it works
// - source port don't-care ignores frame source port
// - source exact mode matches only equal 16-bit source port
// - source range mode matches port inside configured bounds
// - destination port don't-care ignores frame destination port
// - destination exact mode matches only equal destination port
// - destination range mode matches port inside configured bounds
// - fin criterion: 0 rejects set flag, 1 requires it, any
// - syn criterion: 0 rejects set flag, 1 requires it, any
// - rst criterion: 0 rejects set flag, 1 requires it, any
// - psh criterion: 0 rejects set flag, 1 requires it, any
// - ack criterion: 0 rejects set flag, 1 requires it, any
// - urg criterion: 0 rejects set flag, 1 requires it, any
// - ethertype criterion evaluated only when the entry class is the ethertype class (frame class input unused)
// - ethertype don't-care accepts any ethertype
// - ethertype exact mode matches only equal ethertype
`timescale 1ns/1ps
`default_nettype none
module alm_matcher (
   input wire logic clock_i,
   input wire logic reset_i,
   // axi4-lite slave
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // parsed header from the port parser
   input wire logic hdr_valid_i,
   input wire logic [1:0] hdr_class_i,
   input wire logic hdr_is_tcp_i,
   input wire logic [15:0] hdr_sport_i,
   input wire logic [15:0] hdr_dport_i,
   input wire logic [5:0] hdr_flags_i,
   input wire logic [15:0] hdr_etype_i,
   // match result
   output logic hit_valid_o,
   output logic hit_o
);
   logic [31:0] ctrl_reg;
   logic [31:0] sport_reg;
   logic [31:0] dport_reg;
   logic [15:0] etype_reg;
   logic [15:0] etype_next;
   logic etype_bad;
   logic [15:0] hit_count_reg;
   logic aw_held_reg;
   logic w_held_reg;
   logic [7:0] awaddr_reg;
   logic [31:0] wdata_reg;
   logic [3:0] wstrb_reg;
   logic [31:0] wmerged;
   logic [31:0] rd_word;
   logic rd_ok;
   logic wr_ok;
   logic do_write;
   logic sport_ok;
   logic dport_ok;
   logic etype_ok;
   logic flags_ok;
   logic [5:0] flag_ok;
   logic hit_valid_reg;
   logic hit_reg;

   // field views of the configuration
   logic [1:0] smode;
   logic [1:0] dmode;
   logic [1:0] emode;
   logic [1:0] entry_class;
   logic entry_en;
   assign smode = ctrl_reg[alm_pkg::CTL_SMODE +: 2];
   assign dmode = ctrl_reg[alm_pkg::CTL_DMODE +: 2];
   assign emode = ctrl_reg[alm_pkg::CTL_EMODE +: 2];
   assign entry_class = ctrl_reg[alm_pkg::CTL_CLASS +: 2];
   assign entry_en = ctrl_reg[alm_pkg::CTL_EN];

   // write channel acceptance, address and data in either order
   assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
   assign s_axi_wready = !w_held_reg && !s_axi_bvalid;
   assign do_write = aw_held_reg && w_held_reg && !s_axi_bvalid;

   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         aw_held_reg <= 1'b0;
         awaddr_reg <= 8'h00;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held_reg <= 1'b1;
         awaddr_reg <= s_axi_awaddr;
      end else if (do_write) begin
         aw_held_reg <= 1'b0;
      end
   end

   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         w_held_reg <= 1'b0;
         wdata_reg <= 32'h0000_0000;
         wstrb_reg <= 4'h0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held_reg <= 1'b1;
         wdata_reg <= s_axi_wdata;
         wstrb_reg <= s_axi_wstrb;
      end else if (do_write) begin
         w_held_reg <= 1'b0;
      end
   end

   // old register word for strobe merging
   always_comb begin
      rd_word = 32'h0000_0000;
      rd_ok = 1'b1;
      if (awaddr_reg == alm_pkg::OFF_CTRL) begin
         rd_word = ctrl_reg;
      end else if (awaddr_reg == alm_pkg::OFF_SPORT) begin
         rd_word = sport_reg;
      end else if (awaddr_reg == alm_pkg::OFF_DPORT) begin
         rd_word = dport_reg;
      end else if (awaddr_reg == alm_pkg::OFF_ETYPE) begin
         rd_word = {16'h0000, etype_reg};
      end else begin
         rd_ok = 1'b0;
      end
   end

   // byte lane merge
   always_comb begin
      for (int b = 0; b < 4; b++) begin
         wmerged[b*8 +: 8] = wstrb_reg[b] ? wdata_reg[b*8 +: 8]
                                          : rd_word[b*8 +: 8];
      end
   end

   // ethertype values that software must not program
   assign etype_next = wmerged[15:0];
   assign etype_bad = (etype_next < alm_pkg::ETYPE_MIN) ||
      (etype_next == alm_pkg::ETYPE_IPV4) ||
      (etype_next == alm_pkg::ETYPE_ARP) ||
      (etype_next == alm_pkg::ETYPE_IPV6);
   assign wr_ok = rd_ok &&
      !((awaddr_reg == alm_pkg::OFF_ETYPE) && etype_bad);

   // configuration registers
   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         ctrl_reg <= alm_pkg::CTRL_RESET;
         sport_reg <= 32'h0000_0000;
         dport_reg <= 32'h0000_0000;
         etype_reg <= alm_pkg::ETYPE_MIN;
      end else if (do_write && wr_ok) begin
         if (awaddr_reg == alm_pkg::OFF_CTRL) begin
            ctrl_reg <= wmerged;
         end else if (awaddr_reg == alm_pkg::OFF_SPORT) begin
            sport_reg <= wmerged;
         end else if (awaddr_reg == alm_pkg::OFF_DPORT) begin
            dport_reg <= wmerged;
         end else if (awaddr_reg == alm_pkg::OFF_ETYPE) begin
            etype_reg <= etype_next;
         end
      end
   end

   // write response
   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= alm_pkg::RESP_OKAY;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_ok ? alm_pkg::RESP_OKAY : alm_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // read channel, answer one cycle after the address
   assign s_axi_arready = !s_axi_rvalid;
   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= alm_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= alm_pkg::RESP_OKAY;
         if (s_axi_araddr == alm_pkg::OFF_CTRL) begin
            s_axi_rdata <= ctrl_reg;
         end else if (s_axi_araddr == alm_pkg::OFF_SPORT) begin
            s_axi_rdata <= sport_reg;
         end else if (s_axi_araddr == alm_pkg::OFF_DPORT) begin
            s_axi_rdata <= dport_reg;
         end else if (s_axi_araddr == alm_pkg::OFF_ETYPE) begin
            s_axi_rdata <= {16'h0000, etype_reg};
         end else if (s_axi_araddr == alm_pkg::OFF_STAT) begin
            s_axi_rdata <= {15'h0000, hit_reg, hit_count_reg};
         end else begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= alm_pkg::RESP_SLVERR;
         end
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // port criterion checks, bounds inclusive
   function automatic logic port_match(input logic [1:0] mode,
         input logic [31:0] cfg, input logic [15:0] port);
      logic r;
      r = 1'b1;
      if (mode == alm_pkg::MODE_EXACT) begin
         r = (port == cfg[15:0]);
      end else if (mode == alm_pkg::MODE_RANGE) begin
         r = (port >= cfg[15:0]) && (port <= cfg[31:alm_pkg::HI_POS]);
      end
      return r;
   endfunction

   assign sport_ok =
      port_match(smode, sport_reg, hdr_sport_i);
   assign dport_ok =
      port_match(dmode, dport_reg, hdr_dport_i);

   // per flag three-way check, non-tcp frames pass
   generate
      for (genvar f = 0; f < alm_pkg::NUM_FLAGS; f++) begin : g_flag
         logic [1:0] fsel;
         assign fsel = ctrl_reg[alm_pkg::CTL_FLAGS + 2*f +: 2];
         assign flag_ok[f] = !hdr_is_tcp_i ||
            (fsel == alm_pkg::FLAG_ANY) ||
            (fsel == alm_pkg::FLAG_ZERO && !hdr_flags_i[f]) ||
            (fsel == alm_pkg::FLAG_ONE && hdr_flags_i[f]);
      end
   endgenerate
   assign flags_ok = &flag_ok;

   // ethertype check only for the ethertype class
   assign etype_ok = (entry_class != alm_pkg::CLASS_ETYPE) ||
      (emode != alm_pkg::MODE_EXACT) ||
      (hdr_etype_i == etype_reg);

   // registered hit, one cycle after the header
   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         hit_valid_reg <= 1'b0;
         hit_reg <= 1'b0;
      end else begin
         hit_valid_reg <= hdr_valid_i;
         if (hdr_valid_i) begin
            hit_reg <= entry_en && sport_ok && dport_ok && flags_ok &&
               etype_ok;
         end
      end
   end
   assign hit_valid_o = hit_valid_reg;
   assign hit_o = hit_reg;

   // hit counter, wraps
   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         hit_count_reg <= 16'h0000;
      end else if (hit_valid_reg && hit_reg) begin
         hit_count_reg <= hit_count_reg + 16'h0001;
      end
   end

   // checks
   property p_exact_sport;
      @(posedge clock_i) disable iff (reset_i)
      (hdr_valid_i && smode == alm_pkg::MODE_EXACT &&
       hdr_sport_i != sport_reg[15:0]) |=> !hit_o;
   endproperty
   a_exact_sport: assert property (p_exact_sport)
      else $error("sport exact mismatch hit");

   property p_range_dport;
      @(posedge clock_i) disable iff (reset_i)
      (hdr_valid_i && dmode == alm_pkg::MODE_RANGE &&
       (hdr_dport_i < dport_reg[15:0] ||
        hdr_dport_i > dport_reg[31:alm_pkg::HI_POS])) |=> !hit_o;
   endproperty
   a_range_dport: assert property (p_range_dport)
      else $error("dport out of range hit");

   property p_range_sport;
      @(posedge clock_i) disable iff (reset_i)
      (hdr_valid_i && smode == alm_pkg::MODE_RANGE &&
       hdr_sport_i < sport_reg[15:0]) |=> !hit_o;
   endproperty
   a_range_sport: assert property (p_range_sport)
      else $error("sport below range hit");

   property p_exact_dport;
      @(posedge clock_i) disable iff (reset_i)
      (hdr_valid_i && dmode == alm_pkg::MODE_EXACT &&
       hdr_dport_i != dport_reg[15:0]) |=> !hit_o;
   endproperty
   a_exact_dport: assert property (p_exact_dport)
      else $error("dport exact mismatch hit");

   property p_fin_zero;
      @(posedge clock_i) disable iff (reset_i)
      (hdr_valid_i && hdr_is_tcp_i && hdr_flags_i[alm_pkg::FLAG_FIN] &&
       ctrl_reg[alm_pkg::CTL_FLAGS + 2*alm_pkg::FLAG_FIN +: 2] ==
       alm_pkg::FLAG_ZERO) |=> !hit_o;
   endproperty
   a_fin_zero: assert property (p_fin_zero)
      else $error("fin set but hit");

   property p_syn_one;
      @(posedge clock_i) disable iff (reset_i)
      (hdr_valid_i && hdr_is_tcp_i && !hdr_flags_i[alm_pkg::FLAG_SYN] &&
       ctrl_reg[alm_pkg::CTL_FLAGS + 2*alm_pkg::FLAG_SYN +: 2] ==
       alm_pkg::FLAG_ONE) |=> !hit_o;
   endproperty
   a_syn_one: assert property (p_syn_one)
      else $error("syn clear but hit");

   property p_etype_exact;
      @(posedge clock_i) disable iff (reset_i)
      (hdr_valid_i && entry_class == alm_pkg::CLASS_ETYPE &&
       emode == alm_pkg::MODE_EXACT && hdr_etype_i != etype_reg)
      |=> !hit_o;
   endproperty
   a_etype_exact: assert property (p_etype_exact)
      else $error("ethertype mismatch hit");

   property p_all_pass;
      @(posedge clock_i) disable iff (reset_i)
      (hdr_valid_i && entry_en && sport_ok && dport_ok && flags_ok &&
       etype_ok) |=> (hit_valid_o && hit_o);
   endproperty
   a_all_pass: assert property (p_all_pass)
      else $error("all matched but no hit");

   property p_etype_legal;
      @(posedge clock_i) disable iff (reset_i)
      1'b1 |-> etype_reg >= alm_pkg::ETYPE_MIN &&
         etype_reg != alm_pkg::ETYPE_IPV4 &&
         etype_reg != alm_pkg::ETYPE_ARP &&
         etype_reg != alm_pkg::ETYPE_IPV6;
   endproperty
   a_etype_legal: assert property (p_etype_legal)
      else $error("illegal ethertype stored");
endmodule
`default_nettype wire

// [alm_parser_model.sv]
// parser model handing parsed headers to the access control entry matcher
`timescale 1ns/1ps
`default_nettype none
module alm_parser_model (
   input wire logic clock_i,
   output logic hdr_valid_o,
   output logic [1:0] hdr_class_o,
   output logic hdr_is_tcp_o,
   output logic [15:0] hdr_sport_o,
   output logic [15:0] hdr_dport_o,
   output logic [5:0] hdr_flags_o,
   output logic [15:0] hdr_etype_o
);
   logic [56:0] fld;
   // header fields as one bundle
   assign {hdr_class_o, hdr_is_tcp_o, hdr_flags_o, hdr_sport_o, hdr_dport_o,
      hdr_etype_o} = fld;
   // idle until the first header
   initial begin
      hdr_valid_o = 1'h0;
      fld = '0;
   end
   // one-cycle header, then inverted fields so stale values never pass
   task automatic send(input logic [6:0] tf, input logic [15:0] s,
         input logic [15:0] d, input logic [15:0] e);
      @(posedge clock_i);
      hdr_valid_o <= 1'h1;
      fld <= {2'h1, tf, s, d, e};
      @(posedge clock_i);
      hdr_valid_o <= 1'h0;
      fld <= ~{2'h1, tf, s, d, e};
   endtask
endmodule
`default_nettype wire

// [tb.sv]
// self-checking bench for the access control entry matcher
`timescale 1ns/1ps
`default_nettype none
module tb;
   typedef struct packed {
      logic [23:0] ctl;
      logic [31:0] sp, dp;
      logic [6:0] tf;
      logic [15:0] hs, hd, he;
      logic hit;
   } alm_row_t;
   logic clock_i = 1'h0;
   logic reset_i = 1'h1;
   logic [7:0] awaddr = '0, araddr = '0;
   logic [31:0] wdata = '0, rdata, c;
   logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
   logic [3:0] wstrb = 4'hf;
   logic arvalid = 1'h0, rready = 1'h0;
   logic awready, wready, bvalid, arready, rvalid, hit_valid, hit;
   logic [1:0] bresp, rresp, h_class;
   logic h_valid, h_tcp;
   logic [15:0] h_sport, h_dport, h_etype;
   logic [5:0] h_flags;
   logic [15:0] hits = '0;
   logic last = 1'h0;
   int error_cnt = 0, checks = 0, cycles = 0;
   logic [15:0] bad [4] = '{16'h05ff, 16'h0800, 16'h0806, 16'h86dd};
   // ctl, sport, dport, tcp+flags, frame ports, ethertype, hit
   alm_row_t rows [18] = '{
      '{24'h1a_aa00,'0,'0,7'h7f,16'h1234,16'h5678,16'h0800,1'h1},
      '{24'h1a_aa01,32'h0000_ffff,'0,7'h40,16'hffff,'0,'0,1'h1},
      '{24'h1a_aa01,32'h0000_ffff,'0,7'h40,16'hfffe,'0,'0,1'h0},
      '{24'h1a_aa02,32'h0020_0010,'0,7'h40,16'h0010,'0,'0,1'h1},
      '{24'h1a_aa02,32'h0020_0010,'0,7'h40,16'h0020,'0,'0,1'h1},
      '{24'h1a_aa02,32'h0020_0010,'0,7'h40,16'h0021,'0,'0,1'h0},
      '{24'h1a_aa02,32'h0010_0020,'0,7'h40,16'h0015,'0,'0,1'h0},
      '{24'h1a_aa04,'0,'0,7'h40,'0,16'h0000,'0,1'h1},
      '{24'h1a_aa04,'0,'0,7'h40,'0,16'h0001,'0,1'h0},
      '{24'h1a_aa08,'0,32'hffff_fff0,7'h40,'0,16'hffff,'0,1'h1},
      '{24'h1a_aa08,'0,32'hffff_fff0,7'h40,'0,16'hffef,'0,1'h0},
      '{24'h1a_aa50,'0,'0,7'h40,'0,'0,16'h1234,1'h1},
      '{24'h1a_aa50,'0,'0,7'h40,'0,'0,16'h1235,1'h0},
      '{24'h1a_aa10,'0,'0,7'h40,'0,'0,16'h1235,1'h1},
      '{24'h1a_aa40,'0,'0,7'h40,'0,'0,16'h0000,1'h1},
      '{24'h0a_aa00,'0,'0,7'h40,'0,'0,'0,1'h0},
      '{24'h10_0000,'0,'0,7'h3f,'0,'0,'0,1'h1},
      '{24'h1a_aa05,32'h1,32'h2,7'h40,16'h1,16'h3,'0,1'h0}};
   alm_matcher DUT (.clock_i(clock_i), .reset_i(reset_i),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .hdr_valid_i(h_valid),
      .hdr_class_i(h_class), .hdr_is_tcp_i(h_tcp), .hdr_sport_i(h_sport),
      .hdr_dport_i(h_dport), .hdr_flags_i(h_flags), .hdr_etype_i(h_etype),
      .hit_valid_o(hit_valid), .hit_o(hit));
   alm_parser_model P (.clock_i(clock_i), .hdr_valid_o(h_valid),
      .hdr_class_o(h_class), .hdr_is_tcp_o(h_tcp), .hdr_sport_o(h_sport),
      .hdr_dport_o(h_dport), .hdr_flags_o(h_flags), .hdr_etype_o(h_etype));
   // clock and hang limit
   always #5 clock_i = ~clock_i;
   always @(posedge clock_i) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         error_cnt = error_cnt + 1;
         wrap_up();
      end
   end
   // compare and count
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks = checks + 1;
      if (got !== exp) begin
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
         error_cnt = error_cnt + 1;
      end
   endtask
   // bus write: address and data together, each released when taken
   task automatic wr(input logic [7:0] a, input logic [31:0] v,
         input logic [1:0] er);
      logic ta, tw, b;
      logic [1:0] p;
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      do begin
         #1;
         ta = awvalid & awready;
         tw = wvalid & wready;
         @(posedge clock_i);
         if (ta) awvalid <= 1'h0;
         if (tw) wvalid <= 1'h0;
      end while ((awvalid & !ta) | (wvalid & !tw));
      bready <= 1'h1;
      do begin
         #1;
         b = bvalid;
         p = bresp;
         @(posedge clock_i);
      end while (b !== 1'h1);
      bready <= 1'h0;
      chk({30'h0, p}, {30'h0, er});
   endtask
   // bus read: data and response taken at the rvalid edge
   task automatic rd(input logic [7:0] a, input logic [31:0] exp,
         input logic [1:0] er);
      logic r;
      logic [31:0] d;
      logic [1:0] p;
      araddr <= a;
      arvalid <= 1'h1;
      do begin
         #1;
         r = arready;
         @(posedge clock_i);
      end while (r !== 1'h1);
      arvalid <= 1'h0;
      rready <= 1'h1;
      do begin
         #1;
         r = rvalid;
         d = rdata;
         p = rresp;
         @(posedge clock_i);
      end while (r !== 1'h1);
      rready <= 1'h0;
      chk(d, exp);
      chk({30'h0, p}, {30'h0, er});
   endtask
   // one header, result one cycle later, pulse gone after that
   task automatic hdr(input alm_row_t r);
      P.send(r.tf, r.hs, r.hd, r.he);
      #1;
      chk({31'h0, hit_valid}, 32'h1);
      chk({31'h0, hit}, {31'h0, r.hit});
      hits = hits + {15'h0, r.hit};
      last = r.hit;
      @(posedge clock_i);
      #1;
      chk({31'h0, hit_valid}, 32'h0);
      @(posedge clock_i);
   endtask
   // tcp header with given flags against control word c
   task automatic flg(input logic [5:0] f, input logic h);
      hdr('{c[23:0], '0, '0, {1'h1, f}, '0, '0, '0, h});
   endtask
   // verdict
   task automatic wrap_up();
      if (error_cnt == 0 && checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // main sequence
   initial begin
      repeat (2) @(posedge clock_i);
      reset_i <= 1'h0;
      @(posedge clock_i);
      chk({30'h0, hit_valid, hit}, 32'h0);
      rd(alm_pkg::OFF_CTRL, alm_pkg::CTRL_RESET, alm_pkg::RESP_OKAY);
      rd(alm_pkg::OFF_SPORT, 32'h0, alm_pkg::RESP_OKAY);
      rd(alm_pkg::OFF_DPORT, 32'h0, alm_pkg::RESP_OKAY);
      rd(alm_pkg::OFF_ETYPE, 32'h0000_0600, alm_pkg::RESP_OKAY);
      rd(alm_pkg::OFF_STAT, 32'h0, alm_pkg::RESP_OKAY);
      wr(8'h14, 32'h1, alm_pkg::RESP_SLVERR);
      rd(8'h14, 32'h0, alm_pkg::RESP_SLVERR);
      wr(alm_pkg::OFF_ETYPE, 32'h0000_ffff, alm_pkg::RESP_OKAY);
      rd(alm_pkg::OFF_ETYPE, 32'h0000_ffff, alm_pkg::RESP_OKAY);
      wr(alm_pkg::OFF_ETYPE, 32'h0000_0600, alm_pkg::RESP_OKAY);
      foreach (bad[i]) begin
         wr(alm_pkg::OFF_ETYPE, {16'h0, bad[i]},
            alm_pkg::RESP_SLVERR);
         rd(alm_pkg::OFF_ETYPE, 32'h0000_0600, alm_pkg::RESP_OKAY);
      end
      wr(alm_pkg::OFF_ETYPE, 32'h0000_1234, alm_pkg::RESP_OKAY);
      foreach (rows[i]) begin
         wr(alm_pkg::OFF_CTRL, {8'h0, rows[i].ctl}, alm_pkg::RESP_OKAY);
         wr(alm_pkg::OFF_SPORT, rows[i].sp, alm_pkg::RESP_OKAY);
         wr(alm_pkg::OFF_DPORT, rows[i].dp, alm_pkg::RESP_OKAY);
         hdr(rows[i]);
      end
      // each flag: must be clear, then must be set
      for (int k = 0; k < alm_pkg::NUM_FLAGS; k++) begin
         c = 32'h001a_aa00 & ~(32'h0000_0003 << (8 + 2 * k));
         wr(alm_pkg::OFF_CTRL, c, alm_pkg::RESP_OKAY);
         flg(6'h01 << k, 1'h0);
         flg(~(6'h01 << k), 1'h1);
         c = c | (32'h0000_0001 << (8 + 2 * k));
         wr(alm_pkg::OFF_CTRL, c, alm_pkg::RESP_OKAY);
         flg(6'h01 << k, 1'h1);
         flg(6'h00, 1'h0);
      end
      rd(alm_pkg::OFF_STAT, {15'h0, last, hits}, alm_pkg::RESP_OKAY);
      // a hit stands until the next header, then reset in mid-run
      flg(6'h20, 1'h1);
      chk({31'h0, hit}, 32'h1);
      reset_i <= 1'h1;
      repeat (2) @(posedge clock_i);
      reset_i <= 1'h0;
      @(posedge clock_i);
      chk({30'h0, hit_valid, hit}, 32'h0);
      rd(alm_pkg::OFF_CTRL, alm_pkg::CTRL_RESET, alm_pkg::RESP_OKAY);
      rd(alm_pkg::OFF_ETYPE, 32'h0000_0600, alm_pkg::RESP_OKAY);
      rd(alm_pkg::OFF_STAT, 32'h0, alm_pkg::RESP_OKAY);
      // byte strobes keep the unselected lanes
      wr(alm_pkg::OFF_SPORT, 32'h1234_5678, alm_pkg::RESP_OKAY);
      wstrb <= 4'h1;
      wr(alm_pkg::OFF_SPORT, 32'haaaa_aaaa, alm_pkg::RESP_OKAY);
      wstrb <= 4'hf;
      rd(alm_pkg::OFF_SPORT, 32'h1234_56aa, alm_pkg::RESP_OKAY);
      wrap_up();
   end
endmodule
`default_nettype wire
